// ===== hw/bus_pkg.sv
package bus_pkg;

    // ------------------------------------------------------------
    // timing, in ns as specified, and derived clock counts
    // ------------------------------------------------------------
    localparam int TPC_NS = 10;
    localparam int AS_LOW_NS = 35;
    localparam int AS_TO_DS_NS = 40;
    localparam int DS_RD_NS = 135;
    localparam int DS_WR_NS = 80;
    localparam int EXT_STRETCH_TPC = 2;
    localparam int AS_LOW_CYC = (AS_LOW_NS + TPC_NS - 1) / TPC_NS;
    localparam int AS_TO_DS_CYC = (AS_TO_DS_NS + TPC_NS - 1) / TPC_NS;
    localparam int DS_RD_CYC = (DS_RD_NS + TPC_NS - 1) / TPC_NS;
    localparam int DS_WR_CYC = (DS_WR_NS + TPC_NS - 1) / TPC_NS;
    localparam int CNT_W = 5;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int ROM_AW = 13;
    localparam logic [15:0] PC_RESET = 16'h000C;
    localparam logic [15:0] VEC_END = 16'h000C;
    localparam logic [15:0] ROM_TOP = 16'h2000;
    localparam logic [15:0] DATA_BASE = 16'h1000;
    localparam logic [7:0] P0_REG = 8'h00;
    localparam logic [7:0] PORT_LAST = 8'h03;
    localparam logic [7:0] GP_LAST = 8'hEF;
    localparam logic [7:0] BANK_E_LO = 8'hE0;
    localparam logic [7:0] BANK_E_HI = 8'hEF;
    localparam logic [7:0] RP_REG = 8'hFD;
    localparam logic [7:0] SPH_REG = 8'hFE;
    localparam logic [7:0] SPL_REG = 8'hFF;
    localparam logic [7:0] STK_LO = 8'h04;
    localparam logic [7:0] STK_HI = 8'h7F;
    localparam logic [7:0] REFUSED_DATA = 8'hFF;

    // ------------------------------------------------------------
    // software register port
    // ------------------------------------------------------------
    localparam logic [3:0] SW_CFG = 4'h0;
    localparam logic [3:0] SW_STAT = 4'h1;
    localparam logic [3:0] SW_PC = 4'h2;
    localparam logic [3:0] SW_SP = 4'h3;
    localparam logic [3:0] SW_RP = 4'h4;
    localparam int CFG_FLOAT = 0;
    localparam int CFG_P1AD = 1;
    localparam int CFG_P0M = 2;
    localparam int CFG_XTIME = 4;
    localparam int CFG_DMEN = 5;
    localparam int CFG_XSTK = 6;
    localparam int CFG_W = 7;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
    localparam int STAT_REFUSED = 0;
    localparam int STAT_EXTBUSY = 1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        K_IDLE, K_FETCH, K_VEC, K_JUMP, K_DRD, K_DWR, K_PWR, K_RRD, K_RWR, K_PUSH, K_POP
    } req_kind_t;
    typedef enum logic [1:0] {M_DIRECT, M_WORKING, M_INDIRECT} reg_mode_t;
    typedef enum logic [1:0] {P0_IO, P0_NIBBLE, P0_FULL} p0_mode_t;
    typedef enum logic [1:0] {RG_PORT, RG_GP, RG_CTRL} region_t;

    function automatic region_t region_of(input logic [7:0] a);
        if (a <= PORT_LAST) begin
            return RG_PORT;
        end else if (a <= GP_LAST) begin
            return RG_GP;
        end
        return RG_CTRL;
    endfunction

endpackage

// ===== hw/decode_if.sv
`timescale 1ns/10ps
interface decode_if;
    import bus_pkg::*;
    req_kind_t kind;
    reg_mode_t mode;
    logic [15:0] addr;
    logic [15:0] pc;
    logic [7:0] rp;
    logic [15:0] sp;
    logic p1_ad;
    p0_mode_t p0_mode;
    logic xstk;
    logic ext;
    logic write;
    logic dspace;
    logic is_reg;
    logic [7:0] reg_addr;
    logic [15:0] mem_addr;
    logic refused;

    modport requester(
        output kind, mode, addr, pc, rp, sp, p1_ad, p0_mode, xstk,
        input ext, write, dspace, is_reg, reg_addr, mem_addr, refused
    );
    modport decoder(
        input kind, mode, addr, pc, rp, sp, p1_ad, p0_mode, xstk,
        output ext, write, dspace, is_reg, reg_addr, mem_addr, refused
    );
endinterface

// ===== hw/regfile_mem.sv
`timescale 1ns/10ps
module regfile_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter int DW = 8
) (
    input logic sys_clk,
    input logic nrst,
    input logic we,
    input logic [AW-1:0] waddr,
    input logic [DW-1:0] wdata,
    input logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

// ===== hw/addr_decode.sv
`timescale 1ns/10ps
module addr_decode
    import bus_pkg::*;
(
    decode_if.decoder dif
);
    logic [15:0] spn;
    logic [7:0] spl;

    always_comb begin
        dif.ext = 1'b0;
        dif.write = 1'b0;
        dif.dspace = 1'b0;
        dif.is_reg = 1'b0;
        dif.reg_addr = 8'h00;
        dif.mem_addr = 16'h0000;
        dif.refused = 1'b0;
        spn = (dif.kind == K_PUSH) ? dif.sp - 16'h0001 : dif.sp;
        spl = spn[7:0];
        case (dif.kind)
            K_FETCH: begin
                dif.mem_addr = dif.pc;
                dif.ext = (dif.pc >= ROM_TOP);
            end
            K_VEC: begin
                dif.mem_addr = dif.addr;
                dif.refused = (dif.addr >= VEC_END);
            end
            K_DRD, K_DWR: begin
                dif.mem_addr = dif.addr;
                dif.ext = 1'b1;
                dif.dspace = 1'b1;
                dif.write = (dif.kind == K_DWR);
                dif.refused = (dif.addr < DATA_BASE);
            end
            K_PWR: begin
                dif.mem_addr = dif.addr;
                dif.ext = 1'b1;
                dif.write = 1'b1;
                dif.refused = (dif.addr < ROM_TOP);
            end
            K_RRD, K_RWR: begin
                dif.is_reg = 1'b1;
                dif.write = (dif.kind == K_RWR);
                case (dif.mode)
                    M_WORKING: dif.reg_addr = {dif.rp[7:4], dif.addr[3:0]};
                    default: dif.reg_addr = dif.addr[7:0];
                endcase
                dif.refused = (dif.mode == M_DIRECT) && (dif.addr[7:0] >= BANK_E_LO)
                    && (dif.addr[7:0] <= BANK_E_HI);
            end
            K_PUSH, K_POP: begin
                dif.write = (dif.kind == K_PUSH);
                if (dif.xstk) begin
                    dif.ext = 1'b1;
                    dif.dspace = 1'b1;
                    dif.mem_addr = spn;
                    dif.refused = (spn < DATA_BASE);
                end else begin
                    dif.is_reg = 1'b1;
                    dif.reg_addr = spl;
                    dif.refused = (spl < STK_LO) || (spl > STK_HI);
                end
            end
            default: begin
                dif.mem_addr = 16'h0000;
            end
        endcase
        if (dif.ext) begin
            if (!dif.p1_ad) begin
                dif.refused = 1'b1;
            end
            if (dif.p0_mode == P0_IO && dif.mem_addr[15:8] != 8'h00) begin
                dif.refused = 1'b1;
            end
            if (dif.p0_mode == P0_NIBBLE && dif.mem_addr[15:12] != 4'h0) begin
                dif.refused = 1'b1;
            end
        end
    end
endmodule

// ===== hw/bus_unit.sv
`timescale 1ns/10ps
module bus_unit
    import bus_pkg::*;
#(
    parameter int EXT_STRETCH = EXT_STRETCH_TPC
) (
    input logic sys_clk,
    input logic nrst,
    input logic [3:0] sw_addr,
    input logic [15:0] sw_wdata,
    input logic sw_wr,
    input logic sw_rd,
    output logic [15:0] sw_rdata_q,
    input logic req_valid,
    input req_kind_t req_kind,
    input reg_mode_t req_mode,
    input logic [15:0] req_addr,
    input logic [7:0] req_wdata,
    output logic req_ready_q,
    output logic rsp_valid_q,
    output logic [7:0] rsp_data_q,
    output logic rsp_error_q,
    output logic [ROM_AW-1:0] rom_addr_q,
    input logic [7:0] rom_data,
    input logic [7:0] p1_in,
    output logic [7:0] p1_out_q,
    output logic [7:0] p1_oe_n_q,
    output logic [7:0] p0_out_q,
    output logic [7:0] p0_oe_n_q,
    output logic addr_strobe_n_q,
    output logic addr_strobe_oe_n_q,
    output logic data_strobe_n_q,
    output logic data_strobe_oe_n_q,
    output logic rw_q,
    output logic rw_oe_n_q,
    output logic data_space_select_n_q
);
    typedef enum {ST_AS, ST_AH, ST_DS, ST_DONE} state_t;

    // ------------------------------------------------------------
    // state and configuration
    // ------------------------------------------------------------
    state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CFG_W-1:0] cfg_q;
    logic [1:0] stat_q;
    logic [15:0] pc_q;
    logic [15:0] sp_q;
    logic [7:0] rp_q;
    logic [7:0] p0_io_q;
    logic [7:0] p1_meta_q, p1_sync_q;
    req_kind_t kind_q;
    logic ext_q, wr_q, dsp_q, isreg_q, refused_q;
    logic [7:0] raddr_q, wdata_q;
    logic [15:0] maddr_q;
    logic p1_drv_q, p1_drv_d;
    logic [7:0] mem_rdata;
    logic take, go_ext, fin, reg_we, cfg_float;
    logic [7:0] p0_mask, p0_hi;
    p0_mode_t p0_mode;

    decode_if dif();

    addr_decode u_dec (
        .dif(dif)
    );

    regfile_mem #(.DEPTH(256), .AW(8), .DW(8)) u_rf (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .we(reg_we),
        .waddr(raddr_q),
        .wdata(wdata_q),
        .raddr(raddr_q),
        .rdata_q(mem_rdata)
    );

    assign p0_mode = p0_mode_t'(cfg_q[CFG_P0M +: 2]);
    assign cfg_float = cfg_q[CFG_FLOAT];
    assign dif.kind = req_valid ? req_kind : K_IDLE;
    assign dif.mode = req_mode;
    assign dif.addr = req_addr;
    assign dif.pc = pc_q;
    assign dif.rp = rp_q;
    assign dif.sp = sp_q;
    assign dif.p1_ad = cfg_q[CFG_P1AD];
    assign dif.p0_mode = p0_mode;
    assign dif.xstk = cfg_q[CFG_XSTK];

    assign take = req_ready_q;
    assign go_ext = ext_q && !refused_q;
    assign fin = (state_d == ST_DONE) && (state_q != ST_DONE);
    assign reg_we = isreg_q && wr_q && !refused_q && (state_q == ST_AH) && (cnt_q == '0);

    // ------------------------------------------------------------
    // machine cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_DONE: state_d = ST_AS;
            ST_AS: begin
                if (cnt_q == '0) begin
                    state_d = ST_AH;
                end
            end
            ST_AH: begin
                if (cnt_q == '0) begin
                    state_d = go_ext ? ST_DS : ST_DONE;
                end
            end
            ST_DS: begin
                if (cnt_q == '0) begin
                    state_d = ST_DONE;
                end
            end
            default: state_d = ST_DONE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= ST_DONE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (state_d != state_q) begin
            case (state_d)
                ST_AS: cnt_q <= CNT_W'(AS_LOW_CYC - 1);
                ST_AH: cnt_q <= CNT_W'(AS_TO_DS_CYC - 1);
                ST_DS: cnt_q <= CNT_W'((wr_q ? DS_WR_CYC : DS_RD_CYC)
                    + (cfg_q[CFG_XTIME] ? EXT_STRETCH : 0) - 1);
                default: cnt_q <= '0;
            endcase
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            req_ready_q <= 1'b1;
        end else begin
            req_ready_q <= (state_d == ST_DONE);
        end
    end

    // ------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            kind_q <= K_IDLE;
            ext_q <= 1'b0;
            wr_q <= 1'b0;
            dsp_q <= 1'b0;
            isreg_q <= 1'b0;
            refused_q <= 1'b0;
            raddr_q <= 8'h00;
            wdata_q <= 8'h00;
            maddr_q <= 16'h0000;
        end else if (take) begin
            kind_q <= dif.kind;
            ext_q <= dif.ext;
            wr_q <= dif.write;
            dsp_q <= dif.dspace;
            isreg_q <= dif.is_reg;
            refused_q <= dif.refused;
            raddr_q <= dif.reg_addr;
            wdata_q <= req_wdata;
            maddr_q <= dif.mem_addr;
        end
    end

    // ------------------------------------------------------------
    // program counter, stack pointer, register pointer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pc_q <= PC_RESET;
        end else if (take && dif.kind == K_FETCH && !dif.refused) begin
            pc_q <= pc_q + 16'h0001;
        end else if (take && dif.kind == K_JUMP) begin
            pc_q <= req_addr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sp_q <= 16'h0000;
            rp_q <= 8'h00;
        end else if (take && !dif.refused && (dif.kind == K_PUSH || dif.kind == K_POP)) begin
            if (cfg_q[CFG_XSTK]) begin
                sp_q <= (dif.kind == K_PUSH) ? sp_q - 16'h0001 : sp_q + 16'h0001;
            end else begin
                sp_q[7:0] <= (dif.kind == K_PUSH) ? sp_q[7:0] - 8'h01 : sp_q[7:0] + 8'h01;
            end
        end else if (reg_we && region_of(raddr_q) == RG_CTRL) begin
            case (raddr_q)
                RP_REG: rp_q <= wdata_q;
                SPH_REG: sp_q[15:8] <= wdata_q;
                SPL_REG: sp_q[7:0] <= wdata_q;
                default: rp_q <= rp_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            p0_io_q <= 8'h00;
        end else if (reg_we && raddr_q == P0_REG) begin
            p0_io_q <= wdata_q;
        end
    end

    // ------------------------------------------------------------
    // answer to the core
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            p1_meta_q <= 8'h00;
            p1_sync_q <= 8'h00;
        end else begin
            p1_meta_q <= p1_in;
            p1_sync_q <= p1_meta_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rsp_valid_q <= 1'b0;
            rsp_error_q <= 1'b0;
            rsp_data_q <= 8'h00;
        end else begin
            rsp_valid_q <= fin && (kind_q != K_IDLE);
            rsp_error_q <= fin && (kind_q != K_IDLE) && refused_q;
            if (!fin) begin
                rsp_data_q <= 8'h00;
            end else if (refused_q) begin
                rsp_data_q <= REFUSED_DATA;
            end else if (wr_q) begin
                rsp_data_q <= 8'h00;
            end else if (ext_q) begin
                rsp_data_q <= p1_sync_q;
            end else if (kind_q == K_FETCH || kind_q == K_VEC) begin
                rsp_data_q <= rom_data;
            end else if (isreg_q) begin
                case (raddr_q)
                    RP_REG: rsp_data_q <= rp_q;
                    SPH_REG: rsp_data_q <= sp_q[15:8];
                    SPL_REG: rsp_data_q <= sp_q[7:0];
                    default: rsp_data_q <= mem_rdata;
                endcase
            end else begin
                rsp_data_q <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rom_addr_q <= '0;
        end else if (take && !dif.ext && (dif.kind == K_FETCH || dif.kind == K_VEC)) begin
            rom_addr_q <= dif.mem_addr[ROM_AW-1:0];
        end
    end

    // ------------------------------------------------------------
    // external bus pins
    // ------------------------------------------------------------
    always_comb begin
        p1_drv_d = p1_drv_q;
        if (take) begin
            p1_drv_d = cfg_q[CFG_P1AD];
        end else if (state_d == ST_DS && state_q != ST_DS && !wr_q) begin
            p1_drv_d = 1'b0;
        end
    end

    always_comb begin
        case (p0_mode)
            P0_NIBBLE: p0_mask = 8'h0F;
            P0_FULL: p0_mask = 8'hFF;
            default: p0_mask = 8'h00;
        endcase
        p0_hi = take ? dif.mem_addr[15:8] : maddr_q[15:8];
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            p1_drv_q <= 1'b0;
            p1_out_q <= 8'h00;
            p1_oe_n_q <= 8'hFF;
        end else begin
            p1_drv_q <= p1_drv_d;
            p1_oe_n_q <= {8{cfg_float | !p1_drv_d}};
            if (take) begin
                p1_out_q <= dif.mem_addr[7:0];
            end else if (state_d == ST_DS && state_q != ST_DS && wr_q) begin
                p1_out_q <= wdata_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            p0_out_q <= 8'h00;
            p0_oe_n_q <= 8'h00;
        end else begin
            p0_out_q <= (p0_hi & p0_mask) | (p0_io_q & ~p0_mask);
            p0_oe_n_q <= cfg_float ? p0_mask : 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            addr_strobe_n_q <= 1'b1;
            data_strobe_n_q <= 1'b1;
            rw_q <= 1'b1;
            data_space_select_n_q <= 1'b1;
            addr_strobe_oe_n_q <= 1'b0;
            data_strobe_oe_n_q <= 1'b0;
            rw_oe_n_q <= 1'b0;
        end else begin
            addr_strobe_n_q <= (state_d != ST_AS);
            data_strobe_n_q <= (state_d != ST_DS);
            addr_strobe_oe_n_q <= cfg_float;
            data_strobe_oe_n_q <= cfg_float;
            rw_oe_n_q <= cfg_float;
            if (take) begin
                rw_q <= !(dif.ext && dif.write && !dif.refused);
                data_space_select_n_q <= !(cfg_q[CFG_DMEN] && dif.dspace && dif.ext
                    && !dif.refused);
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cfg_q <= CFG_RESET;
        end else if (sw_wr && sw_addr == SW_CFG) begin
            cfg_q <= sw_wdata[CFG_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stat_q <= 2'b00;
        end else begin
            stat_q[STAT_EXTBUSY] <= go_ext && (state_d != ST_DONE);
            if (fin && refused_q && kind_q != K_IDLE) begin
                stat_q[STAT_REFUSED] <= 1'b1;
            end else if (sw_wr && sw_addr == SW_STAT && sw_wdata[STAT_REFUSED]) begin
                stat_q[STAT_REFUSED] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sw_rdata_q <= 16'h0000;
        end else if (sw_rd) begin
            case (sw_addr)
                SW_CFG: sw_rdata_q <= {{(16 - CFG_W){1'b0}}, cfg_q};
                SW_STAT: sw_rdata_q <= {14'h0000, stat_q};
                SW_PC: sw_rdata_q <= pc_q;
                SW_SP: sw_rdata_q <= sp_q;
                SW_RP: sw_rdata_q <= {8'h00, rp_q};
                default: sw_rdata_q <= 16'h0000;
            endcase
        end else begin
            sw_rdata_q <= 16'h0000;
        end
    end
endmodule

// ===== testbench/bus_unit_assertions.sv
`timescale 1ns/10ps
module bus_unit_assertions (
    input logic sys_clk,
    input logic nrst,
    input logic req_ready_q,
    input logic rsp_valid_q,
    input logic [7:0] rsp_data_q,
    input logic rsp_error_q,
    input logic [7:0] p1_out_q,
    input logic [7:0] p1_oe_n_q,
    input logic addr_strobe_n_q,
    input logic addr_strobe_oe_n_q,
    input logic data_strobe_n_q,
    input logic data_strobe_oe_n_q,
    input logic rw_q,
    input logic rw_oe_n_q
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_as;
        !addr_strobe_n_q [*4] ##1 addr_strobe_n_q;
    endsequence
    sequence s_ds;
        !data_strobe_n_q [*8] ##[1:9] data_strobe_n_q;
    endsequence
    property p_as_len; $fell(addr_strobe_n_q) |-> s_as; endproperty
    a_as_len: assert property (p_as_len) else $error("as width");
    property p_as_go; req_ready_q |=> $fell(addr_strobe_n_q); endproperty
    a_as_go: assert property (p_as_go) else $error("as late");
    property p_ds_len; $fell(data_strobe_n_q) |-> s_ds; endproperty
    a_ds_len: assert property (p_ds_len) else $error("ds width");
    property p_ds_in; !data_strobe_n_q |-> addr_strobe_n_q; endproperty
    a_ds_in: assert property (p_ds_in) else $error("ds overlaps as");
    property p_adr; $rose(addr_strobe_n_q) && p1_oe_n_q == 8'h00 |-> $stable(p1_out_q); endproperty
    a_adr: assert property (p_adr) else $error("address moves at as");
    property p_wr; !data_strobe_n_q && !rw_q |-> p1_oe_n_q == 8'h00; endproperty
    a_wr: assert property (p_wr) else $error("write not driven");
    property p_rd; !data_strobe_n_q && rw_q |-> p1_oe_n_q == 8'hFF; endproperty
    a_rd: assert property (p_rd) else $error("read not floated");
    property p_flt; addr_strobe_oe_n_q |-> data_strobe_oe_n_q && rw_oe_n_q && &p1_oe_n_q; endproperty
    a_flt: assert property (p_flt) else $error("partial float");
    property p_err; rsp_error_q |-> rsp_valid_q && rsp_data_q == 8'hFF; endproperty
    a_err: assert property (p_err) else $error("refusal data");
endmodule
bind bus_unit bus_unit_assertions chk (.*);

// ===== testbench/ext_mem_model.sv
`timescale 1ns/10ps
module ext_mem_model (
    input logic sys_clk,
    input logic [7:0] p1_out_q,
    input logic addr_strobe_n_q,
    input logic data_strobe_n_q,
    input logic rw_q,
    output logic [7:0] p1_in
);
    logic [7:0] lat_q = 8'h00;
    initial p1_in = 8'h00;
    always @(posedge sys_clk) begin
        if (!addr_strobe_n_q)
            lat_q <= p1_out_q;
        if (!data_strobe_n_q && rw_q)
            p1_in <= lat_q ^ 8'h3C;
        else
            p1_in <= ~p1_in;
    end
endmodule

// ===== testbench/bus_unit_test.sv
`timescale 1ns/10ps
module bus_unit_test;
    import bus_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [15:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic req_valid = 1'b0;
    req_kind_t req_kind = K_IDLE;
    reg_mode_t req_mode = M_DIRECT;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic [15:0] sw_rdata_q;
    logic req_ready_q, rsp_valid_q, rsp_error_q, rw_q, addr_strobe_n_q;
    logic addr_strobe_oe_n_q, data_strobe_n_q, data_space_select_n_q;
    logic [7:0] rsp_data_q, p1_in, p1_out_q, p1_oe_n_q, rom_data, d;
    logic [ROM_AW-1:0] rom_addr_q;
    logic [10:0] exp_q[$];
    logic [10:0] e;
    logic [31:0] r;
    int mismatches = 0;
    int tests_run = 0;
    always #5 sys_clk = ~sys_clk;
    assign rom_data = rom_addr_q[7:0] ^ 8'h5A;
    bus_unit dut (.*, .p0_out_q(), .p0_oe_n_q(), .data_strobe_oe_n_q(), .rw_oe_n_q());
    ext_mem_model mem (.*);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [15:0] v);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [3:0] a, input logic [15:0] v);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        #1;
        check(sw_rdata_q, v);
        @(posedge sys_clk);
    endtask
    // {data-space select, data compared, error, data}
    task automatic req(input req_kind_t k, input reg_mode_t m, input logic [15:0] a,
        input logic [7:0] w, input logic [9:0] x);
        exp_q.push_back({!((k == K_DRD || k == K_DWR) && !x[8]), x});
        req_kind <= k;
        req_mode <= m;
        req_addr <= a;
        req_wdata <= w;
        req_valid <= 1'b1;
        @(posedge sys_clk);
        while (req_ready_q !== 1'b1) @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        if (rsp_valid_q === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check({6'h00, data_space_select_n_q, rsp_error_q, e[9] ? rsp_data_q : e[7:0]},
                {6'h00, e[10], e[8:0]});
        end
    end
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        r = $urandom(32'hCDEC);
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        sw_read(SW_PC, 16'h000C);
        sw_read(4'hF, 16'h0000);
        sw_write(SW_CFG, 16'h002A);
        sw_read(SW_CFG, 16'h002A);
        req(K_JUMP, M_DIRECT, 16'h1FFF, 8'h00, 10'h000);
        req(K_FETCH, M_DIRECT, 16'h1FFF, 8'h00, 10'h2A5);
        sw_read(SW_PC, 16'h2000);
        req(K_VEC, M_DIRECT, 16'h000B, 8'h00, 10'h251);
        req(K_VEC, M_DIRECT, 16'h000C, 8'h00, 10'h3FF);
        req(K_PWR, M_DIRECT, 16'h1FFF, 8'h00, 10'h3FF);
        req(K_DRD, M_DIRECT, 16'h0FFF, 8'h00, 10'h3FF);
        req(K_RRD, M_DIRECT, 16'h00E5, 8'h00, 10'h3FF);
        repeat (3) begin
            r = $urandom_range(32'hFFFF, 32'h1000);
            d = 8'($urandom);
            req(K_DRD, M_DIRECT, r[15:0], 8'h00, {2'b10, r[7:0] ^ 8'h3C});
            req(K_DWR, M_DIRECT, r[15:0], d, 10'h000);
            req(K_JUMP, M_DIRECT, r[15:0] | 16'h2000, 8'h00, 10'h000);
            req(K_FETCH, M_DIRECT, r[15:0] | 16'h2000, 8'h00, {2'b10, r[7:0] ^ 8'h3C});
            req(K_RWR, M_DIRECT, 16'h0005, d, 10'h000);
            req(K_RRD, M_WORKING, 16'h0005, 8'h00, {2'b10, d});
            req(K_RWR, M_INDIRECT, 16'h00E5, ~d, 10'h000);
            req(K_RRD, M_INDIRECT, 16'h00E5, 8'h00, {2'b10, ~d});
            req(K_RRD, M_DIRECT, 16'h0005, 8'h00, {2'b10, d});
        end
        for (int i = 0; i < 99 && exp_q.size() > 0; i++) @(posedge sys_clk);
        check(16'(exp_q.size()), 16'h0000);
        sw_write(SW_CFG, 16'h002B);
        repeat (3) @(posedge sys_clk);
        check({15'h0000, addr_strobe_oe_n_q}, 16'h0001);
        conclude();
    end
endmodule
